//--- rtl/rsse_core.sv
// Top: AXI4-Lite reachable executer for rotate, subtract and sleep opcodes
`timescale 1ns/1ns
`default_nettype none
module rsse_core
  import rsse_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address channel
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // Write data channel
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // Write response channel
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // Read data channel
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Core state
  output logic                   core_asleep
);

  // ---------------------------------------------------------------
  // State of the whole block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [FILE_DEPTH-1:0][7:0] file;
    logic [7:0]                 acc;
    logic [INSTR_W-1:0]         last_instr;
    logic                       c;
    logic                       hc;
    logic                       z;
    logic                       pd;
    logic                       to;
    logic                       asleep;
    logic [FADDR_W-1:0]         findex;
    logic [7:0]                 watchdog_counter;
    logic [7:0]                 prescaler;
    logic                       aw_got;
    logic [ADDR_W-1:0]          aw_addr;
    logic                       w_got;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [1:0]                 rresp;
    logic [31:0]                rdata;
  } rsse_state_s;

  rsse_state_s state_reg;
  rsse_state_s state_next;

  // ---------------------------------------------------------------
  // Decode and datapath on the pending write word
  // ---------------------------------------------------------------
  rsse_op_e           dec_op;
  logic               dec_dest;
  logic [FADDR_W-1:0] dec_faddr;
  logic [7:0]         dec_literal;
  logic [7:0]         alu_operand;
  logic [7:0]         alu_result;
  logic               alu_c;
  logic               alu_hc;
  logic               alu_z;
  logic [31:0]        wr_word;

  // Byte lanes without a strobe keep zero; registers are narrow
  assign wr_word = state_reg.w_data & {{8{state_reg.w_strb[3]}}, {8{state_reg.w_strb[2]}},
                                       {8{state_reg.w_strb[1]}}, {8{state_reg.w_strb[0]}}};

  rsse_decode u_decode (
    .instr   (wr_word[INSTR_W-1:0]),
    .op      (dec_op),
    .dest    (dec_dest),
    .faddr   (dec_faddr),
    .literal (dec_literal)
  );

  // Literal form takes the immediate, the others the addressed register
  assign alu_operand = (dec_op == OP_SUBL) ? dec_literal : state_reg.file[dec_faddr];

  rsse_alu u_alu (
    .op      (dec_op),
    .operand (alu_operand),
    .acc     (state_reg.acc),
    .c_in    (state_reg.c),
    .result  (alu_result),
    .c_out   (alu_c),
    .hc_out  (alu_hc),
    .z_out   (alu_z)
  );

  // ---------------------------------------------------------------
  // Next-state logic: watchdog, bus slave, instruction execution
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Watchdog keeps its own time base, so it also runs while asleep
    state_next.prescaler = state_reg.prescaler + 8'h01;
    if (state_reg.prescaler == 8'hFF) begin
      state_next.watchdog_counter = state_reg.watchdog_counter + 8'h01;
    end

    // Address and data are caught independently, in either order
    if (awvalid && state_reg.awready) begin
      state_next.aw_got  = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && state_reg.wready) begin
      state_next.w_got  = 1'b1;
      state_next.w_data = wdata;
      state_next.w_strb = wstrb;
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end

    // Commit once both halves are held and the last response is gone
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = RESP_OKAY;
      unique case (state_reg.aw_addr)
        ADDR_W'(OFS_INSTR): begin
          // Halted core executes nothing; unknown words are refused too
          if (state_reg.asleep || dec_op == OP_NONE) begin
            state_next.bresp = RESP_SLVERR;
          end else begin
            state_next.last_instr = wr_word[INSTR_W-1:0];
            if (dec_op == OP_SLEEP) begin
              state_next.pd               = 1'b0;
              state_next.to               = 1'b1;
              state_next.watchdog_counter = 8'h00;
              state_next.prescaler        = 8'h00;
              state_next.asleep           = 1'b1;                // C, HC and Z untouched
            end else if (dec_op == OP_SUBL) begin
              state_next.acc = alu_result;
              state_next.c   = alu_c;
              state_next.hc  = alu_hc;
              state_next.z   = alu_z;
            end else begin
              // Rotate or register subtract, one cycle each
              if (dec_dest == DEST_ACC) begin
                state_next.acc = alu_result;
              end else begin
                state_next.file[dec_faddr] = alu_result;
              end
              state_next.c = alu_c;
              if (dec_op == OP_SUBF) begin
                state_next.hc = alu_hc;
                state_next.z  = alu_z;
              end
            end
          end
        end
        ADDR_W'(OFS_ACC): begin
          state_next.acc = wr_word[7:0];
        end
        ADDR_W'(OFS_STATUS): begin
          state_next.c  = wr_word[ST_C];
          state_next.hc = wr_word[ST_HC];
          state_next.z  = wr_word[ST_Z];
        end
        ADDR_W'(OFS_FINDEX): begin
          state_next.findex = wr_word[FADDR_W-1:0];
        end
        ADDR_W'(OFS_FDATA): begin
          state_next.file[state_reg.findex] = wr_word[7:0];
        end
        ADDR_W'(OFS_WDOG): begin
          // Read-only counter view; write accepted and dropped
        end
        ADDR_W'(OFS_CTRL): begin
          // Wake event restarts execution
          if (wr_word[CTRL_WAKE]) begin
            state_next.asleep = 1'b0;
          end
        end
        default: begin
          state_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read: one item in flight, data one cycle after the address
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    if (arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = RESP_OKAY;
      state_next.rdata  = 32'h0000_0000;
      unique case (araddr)
        ADDR_W'(OFS_INSTR):  state_next.rdata[INSTR_W-1:0] = state_reg.last_instr;
        ADDR_W'(OFS_ACC):    state_next.rdata[7:0]         = state_reg.acc;
        ADDR_W'(OFS_STATUS): begin
          state_next.rdata[ST_C]     = state_reg.c;
          state_next.rdata[ST_HC]    = state_reg.hc;
          state_next.rdata[ST_Z]     = state_reg.z;
          state_next.rdata[ST_PD]    = state_reg.pd;
          state_next.rdata[ST_TO]    = state_reg.to;
          state_next.rdata[ST_SLEEP] = state_reg.asleep;
        end
        ADDR_W'(OFS_FINDEX): state_next.rdata[FADDR_W-1:0] = state_reg.findex;
        ADDR_W'(OFS_FDATA):  state_next.rdata[7:0]         = state_reg.file[state_reg.findex];
        ADDR_W'(OFS_WDOG):   state_next.rdata[15:0]        = {state_reg.prescaler,
                                                              state_reg.watchdog_counter};
        ADDR_W'(OFS_CTRL):   state_next.rdata              = 32'h0000_0000;
        default:             state_next.rresp              = RESP_SLVERR;
      endcase
    end

    // Ready only while the matching holding slot is free
    state_next.awready = !state_next.aw_got;
    state_next.wready  = !state_next.w_got;
    state_next.arready = !state_next.rvalid;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= '0;
      state_reg.pd <= RST_PD;
      state_reg.to <= RST_TO;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs straight from the state flops
  // ---------------------------------------------------------------
  assign awready     = state_reg.awready;
  assign wready      = state_reg.wready;
  assign bvalid      = state_reg.bvalid;
  assign bresp       = state_reg.bresp;
  assign arready     = state_reg.arready;
  assign rvalid      = state_reg.rvalid;
  assign rresp       = state_reg.rresp;
  assign rdata       = state_reg.rdata;
  assign core_asleep = state_reg.asleep;

endmodule : rsse_core
`default_nettype wire

//--- rtl/rsse_pkg.sv
// Package: constants, encodings and register map of the rotate/subtract/sleep executer
//
// Notes on behaviour
// - A rotate-left opcode shifts the addressed register left through carry, old bit 7 to carry, old carry to bit 0, and only carry changes.
// - For rotate-left, destination bit 0 puts the result in the accumulator and 1 puts it back in the addressed register.
// - The sleep opcode clears the power-down flag.
// - The sleep opcode sets the watchdog expiry flag.
// - The sleep opcode loads the watchdog counter with zero and clears its prescaler.
// - After sleep the core halts and executes nothing until a wake event.
// - The literal-subtract opcode computes literal minus accumulator into the accumulator and updates carry, half-carry and zero.
// - The register-subtract opcode computes register minus accumulator and updates carry, half-carry and zero.
// - For register-subtract, destination bit 0 puts the difference in the accumulator and 1 back in the register.
// - After a subtraction carry is an inverted borrow: one for a result of zero or more, zero for a negative one.
package rsse_pkg;

  // ---------------------------------------------------------------
  // Instruction word layout
  // ---------------------------------------------------------------
  localparam int          INSTR_W      = 14;
  localparam int          FADDR_W      = 7;
  localparam int          FILE_DEPTH   = 128;
  localparam int          DEST_BIT     = 7;
  localparam logic [5:0]  OPC_ROT_L    = 6'h0D;   // 00 1101 dfff ffff
  localparam logic [5:0]  OPC_SUB_F    = 6'h02;   // 00 0010 dfff ffff
  localparam logic [4:0]  OPC_SUB_L    = 5'h1E;   // 11 110x kkkk kkkk
  localparam logic [13:0] OPC_SLEEP    = 14'h0063;
  localparam logic        DEST_ACC     = 1'b0;

  // ---------------------------------------------------------------
  // Decoded operations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_ROT   = 3'b001,
    OP_SUBF  = 3'b010,
    OP_SUBL  = 3'b011,
    OP_SLEEP = 3'b100
  } rsse_op_e;

  // ---------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_INSTR    = 8'h00;
  localparam logic [7:0]  OFS_ACC      = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_FINDEX   = 8'h0C;
  localparam logic [7:0]  OFS_FDATA    = 8'h10;
  localparam logic [7:0]  OFS_WDOG     = 8'h14;
  localparam logic [7:0]  OFS_CTRL     = 8'h18;

  // Status and control fields
  localparam int          ST_C         = 0;
  localparam int          ST_HC        = 1;
  localparam int          ST_Z         = 2;
  localparam int          ST_PD        = 3;
  localparam int          ST_TO        = 4;
  localparam int          ST_SLEEP     = 5;
  localparam int          CTRL_WAKE    = 0;

  // Reset values
  localparam logic        RST_PD       = 1'b1;
  localparam logic        RST_TO       = 1'b1;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage : rsse_pkg

//--- rtl/rsse_decode.sv
// Instruction decoder for the four handled opcodes
`timescale 1ns/1ns
`default_nettype none
module rsse_decode
  import rsse_pkg::*;
(
  // Instruction in
  input  wire logic [INSTR_W-1:0] instr,
  // Decoded fields
  output rsse_op_e                op,
  output logic                    dest,
  output logic [FADDR_W-1:0]      faddr,
  output logic [7:0]              literal
);

  // ---------------------------------------------------------------
  // Field extraction and opcode match
  // ---------------------------------------------------------------
  assign dest    = instr[DEST_BIT];
  assign faddr   = instr[FADDR_W-1:0];
  assign literal = instr[7:0];

  always_comb begin
    op = OP_NONE;
    if (instr[13:8] == OPC_ROT_L) begin
      op = OP_ROT;
    end else if (instr[13:8] == OPC_SUB_F) begin
      op = OP_SUBF;
    end else if (instr[13:9] == OPC_SUB_L) begin
      op = OP_SUBL;
    end else if (instr == OPC_SLEEP) begin
      op = OP_SLEEP;
    end
  end

endmodule : rsse_decode
`default_nettype wire

//--- rtl/rsse_alu.sv
// Rotate and subtract datapath with flag generation
`timescale 1ns/1ns
`default_nettype none
module rsse_alu
  import rsse_pkg::*;
(
  // Operation and operands
  input  wire rsse_op_e   op,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] acc,
  input  wire logic       c_in,
  // Result and flags
  output logic [7:0]      result,
  output logic            c_out,
  output logic            hc_out,
  output logic            z_out
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  // ---------------------------------------------------------------
  // Operand minus accumulator as add of complement plus one
  // ---------------------------------------------------------------
  assign diff     = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
  assign low_diff = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  always_comb begin
    result = operand;
    c_out  = c_in;
    hc_out = 1'b0;
    if (op == OP_ROT) begin
      result = {operand[6:0], c_in};
      c_out  = operand[7];
    end else if (op == OP_SUBF || op == OP_SUBL) begin
      result = diff[7:0];
      c_out  = diff[8];                      // Carry out means no borrow
      hc_out = low_diff[4];
    end
    z_out = (result == 8'h00);
  end

endmodule : rsse_alu
`default_nettype wire

//--- testbench/rsse_chk.sv
// Port-level checker for the rotate/subtract/sleep executer
`timescale 1ns/1ns
`default_nettype none
module rsse_chk
  import rsse_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Write side
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  // Read side
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  // Core state
  input wire logic              core_asleep
);
  logic [ADDR_W-1:0] aw_l;
  logic [13:0]       w_l;

  // Keep the last taken address and word; the channels may land in either order
  always_ff @(posedge aclk) begin
    if (awvalid && awready) aw_l <= awaddr;
    if (wvalid && wready) w_l <= wdata[13:0];
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Sleep entry and exit
  // ----------------------------------------------------------------
  a_sleep_enters: assert property ($rose(bvalid) && bresp == RESP_OKAY && aw_l == OFS_INSTR
    && w_l == OPC_SLEEP |-> core_asleep) else $error("sleep word did not halt the core");
  a_sleep_cause: assert property ($rose(core_asleep) |-> $rose(bvalid) && aw_l == OFS_INSTR
    && w_l == OPC_SLEEP) else $error("core halted without a sleep word");
  a_wake_cause: assert property ($fell(core_asleep) |-> $rose(bvalid) && aw_l == OFS_CTRL)
    else $error("core woke without a wake write");
  a_asleep_refuse: assert property ($rose(bvalid) && $past(core_asleep) && aw_l == OFS_INSTR
    |-> bresp == RESP_SLVERR) else $error("halted core accepted a word");
  // ----------------------------------------------------------------
  // Fixed-latency answers (read one cycle, write two) and held responses
  // ----------------------------------------------------------------
  a_b_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  a_r_busy: assert property (rvalid |-> !arready)
    else $error("second read taken early");
endmodule : rsse_chk

bind rsse_core rsse_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

//--- testbench/rsse_core_tb.sv
// Self-checking bench for the executer, driven over its register bus
`timescale 1ns/1ns
`default_nettype none
module rsse_core_tb;
  import rsse_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, core_asleep;
  logic [7:0]  awaddr, araddr, a_v, f_v, rb;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [13:0] ins;
  logic [6:0]  fi;
  logic [2:0]  s_v;
  logic [7:0]  m_acc, m_file [128];
  logic        m_c, m_hc, m_z, m_pd, m_to, m_sl;
  int          error_cnt, checks_done, cyc, n, k;
  integer      seed;
  // Hand-picked worked cases ahead of the random run
  logic [7:0]  c_acc [5] = '{8'h00, 8'h02, 8'h02, 8'h03, 8'h00};
  logic [7:0]  c_f [5]   = '{8'hE6, 8'h02, 8'h01, 8'h00, 8'h00};
  logic [13:0] c_ins [5] = '{{OPC_ROT_L, 8'h05}, {OPC_SUB_F, 8'h85}, {OPC_SUB_F, 8'h05},
                             {OPC_SUB_L, 9'h002}, OPC_SLEEP};

  rsse_core dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .core_asleep(core_asleep));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // Cut a hang short; a normal run needs well under a fifth of this
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk_resp

  // ----------------------------------------------------------------
  // Bus cycles; ready on the answer side is raised late at random to stall
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit         aw_d, w_d;
    logic [1:0] r;
    aw_d = 1'b0;
    w_d  = 1'b0;
    r    = 2'b11;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'($random(seed));
    repeat (64) begin
      @(posedge aclk);
      if (bvalid && bready) begin
        r = bresp;
        break;
      end
      if (awready && !aw_d) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_d) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
      if (!bready) bready <= 1'($random(seed));
    end
    bready <= 1'b0;
    chk_resp("bresp", er, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    bit          ar_d;
    logic [31:0] d;
    logic [1:0]  r;
    ar_d = 1'b0;
    d    = 32'hXXXXXXXX;
    r    = 2'b11;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'($random(seed));
    repeat (64) begin
      @(posedge aclk);
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        break;
      end
      if (arready && !ar_d) begin
        ar_d = 1'b1;
        arvalid <= 1'b0;
      end
      if (!rready) rready <= 1'($random(seed));
    end
    rready <= 1'b0;
    chk_resp("rresp", er, r);
    chk_val("rdata", e, d & m);
  endtask : rd

  // Expected effect of one executed word on the bench's copy of the core
  function automatic void model(input logic [13:0] i);
    logic [7:0] a, r;
    a = m_file[i[6:0]];
    if (i == OPC_SLEEP) begin
      m_pd = 1'b0;
      m_to = 1'b1;
      m_sl = 1'b1;
      return;
    end
    if (i[13:9] == OPC_SUB_L) a = i[7:0];
    if (i[13:8] == OPC_ROT_L) begin
      r   = {a[6:0], m_c};
      m_c = a[7];
    end else begin
      r    = a - m_acc;
      m_c  = a >= m_acc;
      m_hc = a[3:0] >= m_acc[3:0];
      m_z  = r == 8'h00;
    end
    if (i[DEST_BIT] == DEST_ACC || i[13:9] == OPC_SUB_L) m_acc = r;
    else m_file[i[6:0]] = r;
  endfunction : model

  function automatic logic [31:0] st_exp();
    return {26'h0, m_sl, m_to, m_pd, m_z, m_hc, m_c};
  endfunction : st_exp

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h2F23308C;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, error_cnt, checks_done, cyc} = '0;
    wstrb = 4'hF;
    {m_acc, m_c, m_hc, m_z, m_sl} = '0;
    {m_pd, m_to} = 2'b11;
    m_file = '{default: 8'h00};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS, st_exp(), 32'hFFFFFFFF, RESP_OKAY);
    wr(8'h40, 32'h0, RESP_SLVERR);
    rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(OFS_INSTR, 32'h0, RESP_SLVERR);
    for (n = 0; n < 160; n++) begin
      a_v = 8'($random(seed));
      f_v = 8'($random(seed));
      fi  = 7'($random(seed));
      rb  = 8'($random(seed));
      s_v = 3'($random(seed));
      k   = $unsigned($random(seed)) % 3;
      ins = k == 0 ? {OPC_ROT_L, rb[7], fi} : k == 1 ? {OPC_SUB_F, rb[7], fi} : {OPC_SUB_L, rb[0], rb};
      if (n % 25 == 24) ins = OPC_SLEEP;
      if (n < 5) begin
        a_v = c_acc[n];
        f_v = c_f[n];
        ins = c_ins[n];
        fi  = ins[6:0];
        s_v = 3'h0;
      end
      m_acc = a_v;
      {m_z, m_hc, m_c} = s_v;
      m_file[fi] = f_v;
      wr(OFS_ACC, {24'h0, a_v}, RESP_OKAY);
      wr(OFS_STATUS, {29'h0, s_v}, RESP_OKAY);
      wr(OFS_FINDEX, {25'h0, fi}, RESP_OKAY);
      wr(OFS_FDATA, {24'h0, f_v}, RESP_OKAY);
      wr(OFS_INSTR, {18'h0, ins}, RESP_OKAY);
      model(ins);
      if (ins == OPC_SLEEP) rd(OFS_WDOG, 32'h0, 32'h0000E0FF, RESP_OKAY);
      rd(OFS_INSTR, {18'h0, ins}, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFS_ACC, {24'h0, m_acc}, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFS_STATUS, st_exp(), 32'hFFFFFFFF, RESP_OKAY);
      rd(OFS_FDATA, {24'h0, m_file[fi]}, 32'hFFFFFFFF, RESP_OKAY);
      if (ins == OPC_SLEEP) begin
        chk_val("core_asleep", 32'h1, {31'h0, core_asleep});
        wr(OFS_INSTR, {18'h0, OPC_ROT_L, 8'h85}, RESP_SLVERR);
        rd(OFS_FDATA, {24'h0, m_file[fi]}, 32'hFFFFFFFF, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        m_sl = 1'b0;
        rd(OFS_STATUS, st_exp(), 32'hFFFFFFFF, RESP_OKAY);
      end
    end
    conclude();
  end
endmodule : rsse_core_tb
`default_nettype wire
